/* hdl/ddc_pkg.sv */
// Shared constants, types and helpers of the Doppler detection configuration bank
package ddc_pkg;

   // Command addresses of the parameter registers
   localparam logic [7:0] ADDR_APPROACH_SENS = 8'h95;
   localparam logic [7:0] ADDR_LEAVE_SENS = 8'h96;
   localparam logic [7:0] ADDR_APPROACH_RESP = 8'h97;
   localparam logic [7:0] ADDR_LEAVE_RESP = 8'h98;
   localparam logic [7:0] ADDR_TARGET_VEL = 8'h99;
   localparam logic [7:0] ADDR_SAMPLE_RATE = 8'h9a;
   localparam logic [7:0] ADDR_NOISE_FILTER = 8'h9b;
   localparam logic [7:0] ADDR_TX_CHANNEL = 8'h9c;
   localparam logic [7:0] ADDR_DETECT_COND = 8'ha0;
   localparam logic [7:0] ADDR_DETECT_INV = 8'ha1;

   // Highest legal code of each parameter
   localparam logic [7:0] MAX_SENS = 8'h64;
   localparam logic [7:0] MAX_RESP = 8'h7f;
   localparam logic [7:0] MAX_VEL = 8'h07;
   localparam logic [7:0] MAX_RATE = 8'h04;
   localparam logic [7:0] MAX_FLAG = 8'h01;
   localparam logic [7:0] MAX_CHANNEL = 8'h09;
   localparam logic [7:0] MAX_COND = 8'h02;

   // Reset values
   localparam logic [6:0] RST_SENS = 7'h14;
   localparam logic [6:0] RST_RESP = 7'h07;
   localparam logic [2:0] RST_VEL = 3'h3;
   localparam logic [2:0] RST_RATE = 3'h0;
   localparam logic RST_NOISE = 1'b1;
   localparam logic [3:0] RST_CHANNEL = 4'h5;
   localparam logic [1:0] RST_COND = 2'h0;
   localparam logic RST_INV = 1'b0;

   // Detection condition codes and output pin mode codes
   localparam logic [1:0] COND_EITHER = 2'h0;
   localparam logic [1:0] COND_APPROACH = 2'h1;
   localparam logic [1:0] COND_LEAVE = 2'h2;
   localparam logic [1:0] PIN_DIGITAL = 2'h0;
   localparam logic [1:0] PIN_PWM = 2'h1;
   localparam logic [1:0] PIN_UART = 2'h2;

   // Response time step and its length in clock cycles
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned RESP_STEP_MS = 16;
   localparam int unsigned RESP_STEP_CYCLES = RESP_STEP_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned STEP_CNT_W = 22;

   // Least sampling rate code allowed for each target velocity code
   localparam logic [7:0][2:0] VEL_MIN_RATE = {3'h4, 3'h3, 3'h2, 3'h1,
                                               3'h0, 3'h0, 3'h0, 3'h0};

   // Register command from the host
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [7:0] data;
   } ddc_cmd_s;

   // Answer to one command
   typedef struct packed {
      logic valid;
      logic error;
      logic [7:0] data;
   } ddc_rsp_s;

   // Stored configuration
   typedef struct packed {
      logic [6:0] approach_sensitivity;
      logic [6:0] leave_sensitivity;
      logic [6:0] approach_response_time;
      logic [6:0] leave_response_time;
      logic [2:0] target_velocity;
      logic [2:0] sampling_rate;
      logic noise_filter_enable;
      logic [3:0] transmit_channel;
      logic [1:0] output_detect_condition;
      logic output_detect_invert;
   } ddc_cfg_s;

   // True when a velocity and sampling rate pair may stand together
   function automatic logic combo_ok(input logic [2:0] vel, input logic [2:0] rate);
      combo_ok = (rate >= VEL_MIN_RATE[vel]);
   endfunction

endpackage

/* hdl/ddc_persist.sv */
// Persistence timer: declares a detection after continuous sensing for the set time
module ddc_persist #(
   parameter int unsigned STEP_CYCLES = ddc_pkg::RESP_STEP_CYCLES
) (
   input wire logic mclk_in,        // Clock
   input wire logic resetn_in,      // Asynchronous reset, active low
   input wire logic sense_in,       // Moving object currently sensed
   input wire logic [6:0] code_in,  // Response time code, (code+1) steps
   output logic detect_out          // Detection declared
);

   localparam int unsigned STEP_CNT_W = ddc_pkg::STEP_CNT_W;

   logic [ddc_pkg::STEP_CNT_W-1:0] cyc_reg, cyc_next;
   logic [7:0] step_reg, step_next;
   logic det_reg, det_next;
   logic [7:0] need;

   // Count whole steps of uninterrupted sensing; any gap restarts the wait
   always_comb begin
      need = {1'b0, code_in} + 8'h01;
      cyc_next = cyc_reg;
      step_next = step_reg;
      det_next = det_reg;
      if (!sense_in) begin
         cyc_next = '0;
         step_next = 8'h00;
         det_next = 1'b0;
      end else if (step_reg >= need) begin
         det_next = 1'b1;
      end else if (cyc_reg == STEP_CNT_W'(STEP_CYCLES - 1)) begin
         cyc_next = '0;
         step_next = step_reg + 8'h01;
         det_next = ((step_reg + 8'h01) >= need);
      end else begin
         cyc_next = cyc_reg + 1'b1;
      end
   end

   // State registers
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cyc_reg <= '0;
         step_reg <= 8'h00;
         det_reg <= 1'b0;
      end else begin
         cyc_reg <= cyc_next;
         step_reg <= step_next;
         det_reg <= det_next;
      end
   end

   assign detect_out = det_reg;

endmodule

/* hdl/ddc_regs.sv */
// Doppler detection configuration registers, command decode and output condition logic
// How it works
// - Approach sensitivity holds 0..100 percent, starts at 20 percent.
// - Leave sensitivity holds 0..100 percent independently, starts at 20 percent.
// - Stored sensitivities apply only while analog sensitivity is off.
// - Approach response time is (code+1) times 16 ms, reset code 0x07.
// - Approach declared only after continuous approach sensing for that time.
// - Leave response time uses same 16 ms steps, reset code 0x07.
// - Leave declared only after continuous leave sensing for that time.
// - Target velocity is a code 0..7, reset code 3.
// - With auto rate on, any velocity 0..7 is stored unchecked.
// - With auto rate off, a bad velocity and rate pair is refused.
// - Sampling rate code 0..4 selects 1 to 16 kHz, reset 0.
// - Stored sampling rate applies only while auto rate is off.
// - With auto rate on, rate writes store even with bad pairs.
// - With auto rate off, a bad rate and velocity pair is refused.
// - Noise filter enable is bit 0, on after reset.
// - Transmit channel 0..9, starts at 5, used when random channel off.
// - Output reacts to approach or leave, approach only, or leave only.
// - Inverse setting flips the output after the condition is judged.
// - Analog sensitivity on uses the measured analog value instead.
// - Pin mode selects digital, PWM or UART; digital by default.
// - Auto rate on uses the rate chosen by the device itself.
module ddc_regs #(
   parameter int unsigned STEP_CYCLES = ddc_pkg::RESP_STEP_CYCLES
) (
   input wire logic mclk_in,                  // Clock, 200 MHz
   input wire logic resetn_in,                // Asynchronous reset, active low
   input wire ddc_pkg::ddc_cmd_s cmd_in,      // Host command
   output ddc_pkg::ddc_rsp_s rsp_out,         // Answer, one cycle after command
   input wire logic analog_sens_en_in,        // Analog sensitivity setting enabled
   input wire logic [6:0] analog_sens_in,     // Sensitivity measured on analog input
   input wire logic auto_rate_en_in,          // Automatic sampling rate enabled
   input wire logic [2:0] auto_rate_in,       // Rate chosen by automatic control
   input wire logic random_chan_en_in,        // Random channel enabled
   input wire logic [3:0] random_chan_in,     // Channel drawn at startup
   input wire logic [1:0] pin_mode_in,        // Output pin mode
   input wire logic approach_sense_in,        // Approaching object sensed now
   input wire logic leave_sense_in,           // Leaving object sensed now
   output logic [6:0] approach_sens_out,      // Sensitivity in use for approach
   output logic [6:0] leave_sens_out,         // Sensitivity in use for leave
   output logic [2:0] target_velocity_out,    // Target velocity code in use
   output logic [2:0] sampling_rate_out,      // Sampling rate code in use
   output logic noise_filter_en_out,          // Noise reduction enabled
   output logic [3:0] tx_channel_out,         // Transmit channel in use
   output logic approach_detect_out,          // Approach detection declared
   output logic leave_detect_out,             // Leave detection declared
   output logic multi_mode_output_pin_out     // Detection level for digital or PWM
);

   ddc_pkg::ddc_cfg_s cfg_reg, cfg_next;
   ddc_pkg::ddc_rsp_s rsp_reg, rsp_next;
   logic wr;
   logic approach_det, leave_det;

   // Command decode, range and pair checks, register update
   always_comb begin
      cfg_next = cfg_reg;
      rsp_next = '0;
      rsp_next.valid = cmd_in.valid;
      wr = cmd_in.valid && cmd_in.write;
      if (cmd_in.addr == ddc_pkg::ADDR_APPROACH_SENS) begin
         rsp_next.data = {1'b0, cfg_reg.approach_sensitivity};
         if (wr && cmd_in.data > ddc_pkg::MAX_SENS) begin
            rsp_next.error = 1'b1;
         end else if (wr) begin
            cfg_next.approach_sensitivity = cmd_in.data[6:0];
         end
      end else if (cmd_in.addr == ddc_pkg::ADDR_LEAVE_SENS) begin
         rsp_next.data = {1'b0, cfg_reg.leave_sensitivity};
         if (wr && cmd_in.data > ddc_pkg::MAX_SENS) begin
            rsp_next.error = 1'b1;
         end else if (wr) begin
            cfg_next.leave_sensitivity = cmd_in.data[6:0];
         end
      end else if (cmd_in.addr == ddc_pkg::ADDR_APPROACH_RESP) begin
         rsp_next.data = {1'b0, cfg_reg.approach_response_time};
         if (wr && cmd_in.data > ddc_pkg::MAX_RESP) begin
            rsp_next.error = 1'b1;
         end else if (wr) begin
            cfg_next.approach_response_time = cmd_in.data[6:0];
         end
      end else if (cmd_in.addr == ddc_pkg::ADDR_LEAVE_RESP) begin
         rsp_next.data = {1'b0, cfg_reg.leave_response_time};
         if (wr && cmd_in.data > ddc_pkg::MAX_RESP) begin
            rsp_next.error = 1'b1;
         end else if (wr) begin
            cfg_next.leave_response_time = cmd_in.data[6:0];
         end
      end else if (cmd_in.addr == ddc_pkg::ADDR_TARGET_VEL) begin
         rsp_next.data = {5'h00, cfg_reg.target_velocity};
         if (wr && cmd_in.data > ddc_pkg::MAX_VEL) begin
            rsp_next.error = 1'b1;
         end else if (wr && !auto_rate_en_in &&
                      !ddc_pkg::combo_ok(cmd_in.data[2:0], cfg_reg.sampling_rate)) begin
            rsp_next.error = 1'b1;
         end else if (wr) begin
            cfg_next.target_velocity = cmd_in.data[2:0];
         end
      end else if (cmd_in.addr == ddc_pkg::ADDR_SAMPLE_RATE) begin
         rsp_next.data = {5'h00, cfg_reg.sampling_rate};
         if (wr && cmd_in.data > ddc_pkg::MAX_RATE) begin
            rsp_next.error = 1'b1;
         end else if (wr && !auto_rate_en_in &&
                      !ddc_pkg::combo_ok(cfg_reg.target_velocity, cmd_in.data[2:0])) begin
            rsp_next.error = 1'b1;
         end else if (wr) begin
            cfg_next.sampling_rate = cmd_in.data[2:0];
         end
      end else if (cmd_in.addr == ddc_pkg::ADDR_NOISE_FILTER) begin
         rsp_next.data = {7'h00, cfg_reg.noise_filter_enable};
         if (wr && cmd_in.data > ddc_pkg::MAX_FLAG) begin
            rsp_next.error = 1'b1;
         end else if (wr) begin
            cfg_next.noise_filter_enable = cmd_in.data[0];
         end
      end else if (cmd_in.addr == ddc_pkg::ADDR_TX_CHANNEL) begin
         rsp_next.data = {4'h0, cfg_reg.transmit_channel};
         if (wr && cmd_in.data > ddc_pkg::MAX_CHANNEL) begin
            rsp_next.error = 1'b1;
         end else if (wr) begin
            cfg_next.transmit_channel = cmd_in.data[3:0];
         end
      end else if (cmd_in.addr == ddc_pkg::ADDR_DETECT_COND) begin
         rsp_next.data = {6'h00, cfg_reg.output_detect_condition};
         if (wr && cmd_in.data > ddc_pkg::MAX_COND) begin
            rsp_next.error = 1'b1;
         end else if (wr) begin
            cfg_next.output_detect_condition = cmd_in.data[1:0];
         end
      end else if (cmd_in.addr == ddc_pkg::ADDR_DETECT_INV) begin
         rsp_next.data = {7'h00, cfg_reg.output_detect_invert};
         if (wr && cmd_in.data > ddc_pkg::MAX_FLAG) begin
            rsp_next.error = 1'b1;
         end else if (wr) begin
            cfg_next.output_detect_invert = cmd_in.data[0];
         end
      end else begin
         rsp_next.error = cmd_in.valid; // Unknown address
      end
      if (!cmd_in.valid) begin
         rsp_next = '0;
      end
   end

   // Configuration and answer registers
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_reg.approach_sensitivity <= ddc_pkg::RST_SENS;
         cfg_reg.leave_sensitivity <= ddc_pkg::RST_SENS;
         cfg_reg.approach_response_time <= ddc_pkg::RST_RESP;
         cfg_reg.leave_response_time <= ddc_pkg::RST_RESP;
         cfg_reg.target_velocity <= ddc_pkg::RST_VEL;
         cfg_reg.sampling_rate <= ddc_pkg::RST_RATE;
         cfg_reg.noise_filter_enable <= ddc_pkg::RST_NOISE;
         cfg_reg.transmit_channel <= ddc_pkg::RST_CHANNEL;
         cfg_reg.output_detect_condition <= ddc_pkg::RST_COND;
         cfg_reg.output_detect_invert <= ddc_pkg::RST_INV;
         rsp_reg <= '0;
      end else begin
         cfg_reg <= cfg_next;
         rsp_reg <= rsp_next;
      end
   end

   // Persistence timers for the two directions
   ddc_persist #(.STEP_CYCLES(STEP_CYCLES)) u_approach (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .sense_in(approach_sense_in),
      .code_in(cfg_reg.approach_response_time),
      .detect_out(approach_det)
   );

   ddc_persist #(.STEP_CYCLES(STEP_CYCLES)) u_leave (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .sense_in(leave_sense_in),
      .code_in(cfg_reg.leave_response_time),
      .detect_out(leave_det)
   );

   // Settings in use and the output pin level
   logic [6:0] app_sens_next, lv_sens_next;
   logic [2:0] rate_next;
   logic [3:0] chan_next;
   logic cond_hit, pin_next;

   always_comb begin
      app_sens_next = analog_sens_en_in ? analog_sens_in
                                        : cfg_reg.approach_sensitivity;
      lv_sens_next = analog_sens_en_in ? analog_sens_in
                                       : cfg_reg.leave_sensitivity;
      rate_next = auto_rate_en_in ? auto_rate_in : cfg_reg.sampling_rate;
      chan_next = random_chan_en_in ? random_chan_in : cfg_reg.transmit_channel;
      case (cfg_reg.output_detect_condition)
         ddc_pkg::COND_APPROACH: cond_hit = approach_det;
         ddc_pkg::COND_LEAVE: cond_hit = leave_det;
         default: cond_hit = approach_det || leave_det;
      endcase
      pin_next = 1'b0;
      if (pin_mode_in == ddc_pkg::PIN_DIGITAL || pin_mode_in == ddc_pkg::PIN_PWM) begin
         pin_next = cond_hit ^ cfg_reg.output_detect_invert;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         approach_sens_out <= ddc_pkg::RST_SENS;
         leave_sens_out <= ddc_pkg::RST_SENS;
         target_velocity_out <= ddc_pkg::RST_VEL;
         sampling_rate_out <= ddc_pkg::RST_RATE;
         noise_filter_en_out <= ddc_pkg::RST_NOISE;
         tx_channel_out <= ddc_pkg::RST_CHANNEL;
         approach_detect_out <= 1'b0;
         leave_detect_out <= 1'b0;
         multi_mode_output_pin_out <= 1'b0;
      end else begin
         approach_sens_out <= app_sens_next;
         leave_sens_out <= lv_sens_next;
         target_velocity_out <= cfg_reg.target_velocity;
         sampling_rate_out <= rate_next;
         noise_filter_en_out <= cfg_reg.noise_filter_enable;
         tx_channel_out <= chan_next;
         approach_detect_out <= approach_det;
         leave_detect_out <= leave_det;
         multi_mode_output_pin_out <= pin_next;
      end
   end

   assign rsp_out = rsp_reg;

endmodule

/* test/ddc_regs_sva.sv */
// Port-level assertions of the detection configuration bank
module ddc_regs_sva #(
   parameter int unsigned STEP_CYCLES = ddc_pkg::RESP_STEP_CYCLES
) (
   input wire logic mclk_in, // Clock
   input wire logic resetn_in, // Reset, active low
   input wire ddc_pkg::ddc_cmd_s cmd_in, // Command
   input wire ddc_pkg::ddc_rsp_s rsp_out, // Answer
   input wire logic analog_sens_en_in, // Analog on
   input wire logic [6:0] analog_sens_in, // Analog value
   input wire logic auto_rate_en_in, // Auto rate on
   input wire logic [2:0] auto_rate_in, // Auto rate
   input wire logic random_chan_en_in, // Random channel on
   input wire logic [3:0] random_chan_in, // Random channel
   input wire logic [1:0] pin_mode_in, // Pin mode
   input wire logic approach_sense_in, // Approach sensed
   input wire logic leave_sense_in, // Leave sensed
   input wire logic [6:0] approach_sens_out, // Approach sensitivity
   input wire logic [6:0] leave_sens_out, // Leave sensitivity
   input wire logic [2:0] target_velocity_out, // Velocity
   input wire logic [2:0] sampling_rate_out, // Rate
   input wire logic noise_filter_en_out, // Noise filter
   input wire logic [3:0] tx_channel_out, // Channel
   input wire logic approach_detect_out, // Approach detect
   input wire logic leave_detect_out, // Leave detect
   input wire logic multi_mode_output_pin_out // Output pin
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   logic [15:0] run_reg;
   logic [15:0] run_next;
   logic wr_valid;
   // Length of the current run of approach sensing, saturating
   always_comb begin
      run_next = (run_reg == 16'hffff) ? run_reg : run_reg + 16'h1;
      if (!approach_sense_in) run_next = 16'h0;
   end
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) run_reg <= 16'h0;
      else run_reg <= run_next;
   end
   assign wr_valid = cmd_in.valid && cmd_in.write;
   // Command timing, refusals and output selection
   a_rsp_one_cycle: assert property (cmd_in.valid |=> rsp_out.valid)
      else $error("no answer one cycle after a command");
   a_rsp_no_extra: assert property (!cmd_in.valid |=> !rsp_out.valid)
      else $error("answer without a command");
   a_sens_range: assert property (wr_valid && cmd_in.addr inside {8'h95, 8'h96}
      && cmd_in.data > 8'h64 |=> rsp_out.error) else $error("sensitivity above range taken");
   a_resp_range: assert property (wr_valid && cmd_in.addr inside {8'h97, 8'h98}
      && cmd_in.data > 8'h7f |=> rsp_out.error) else $error("response time above range taken");
   a_vel_auto: assert property (wr_valid && auto_rate_en_in && cmd_in.addr == 8'h99
      && cmd_in.data <= 8'h07 |=> !rsp_out.error) else $error("velocity refused with auto rate");
   a_sens_analog: assert property (analog_sens_en_in |=>
      approach_sens_out == $past(analog_sens_in) && leave_sens_out == $past(analog_sens_in))
      else $error("analog sensitivity not applied");
   a_rate_auto: assert property (auto_rate_en_in |=>
      sampling_rate_out == $past(auto_rate_in)) else $error("automatic rate not applied");
   a_chan_random: assert property (random_chan_en_in |=>
      tx_channel_out == $past(random_chan_in)) else $error("random channel not applied");
   a_approach_hold: assert property ($rose(approach_detect_out) |->
      $past(run_reg) >= STEP_CYCLES) else $error("approach declared too early");
   a_leave_drop: assert property (!leave_sense_in |-> ##2 !leave_detect_out)
      else $error("leave detection outlived sensing");
   a_pin_uart: assert property (pin_mode_in >= 2'h2 |=> !multi_mode_output_pin_out)
      else $error("output pin active in serial mode");
   // Main scenarios reached
   c_approach: cover property ($rose(approach_detect_out));
   c_leave: cover property ($rose(leave_detect_out));
   c_refused: cover property (wr_valid ##1 rsp_out.error);
endmodule

/* test/ddc_host.sv */
// Host controller model issuing one-byte configuration commands
module ddc_host (
   input wire logic mclk_in, // Clock
   input wire ddc_pkg::ddc_rsp_s rsp_in, // Answer from the bank
   output ddc_pkg::ddc_cmd_s cmd_out // Command to the bank
);
   timeunit 1ns;
   timeprecision 1ps;
   initial cmd_out = '0;
   // One command for one cycle; address and data scrambled once released
   task automatic send(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                       output ddc_pkg::ddc_rsp_s rsp);
      @(posedge mclk_in);
      cmd_out <= '{valid: 1'b1, write: wr, addr: addr, data: data};
      @(posedge mclk_in);
      cmd_out <= '{valid: 1'b0, write: ~wr, addr: ~addr, data: ~data};
      #1 rsp = rsp_in;
   endtask
endmodule

/* test/tb_doppler_detect_config_regs.sv */
// Self-checking bench of the detection configuration bank
module tb_doppler_detect_config_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned STEP = 4;
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic an_en = 1'b0, au_en = 1'b0, rc_en = 1'b0, ap_s = 1'b0, lv_s = 1'b0;
   logic [6:0] an_val = 7'h0;
   logic [2:0] au_val = 3'h0;
   logic [3:0] rc_val = 4'h0;
   logic [1:0] pin = 2'h0;
   logic [6:0] ap_sens, lv_sens;
   logic [2:0] vel, rate;
   logic [3:0] ch;
   logic nf, ap_d, lv_d, multi_mode_output_pin;
   ddc_pkg::ddc_cmd_s cmd;
   ddc_pkg::ddc_rsp_s rsp, r;
   int error_cnt = 0;
   int compares = 0;
   int k;
   logic [7:0] d;
   logic [7:0] ad[10] = '{8'h95, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'ha0, 8'ha1};
   logic [7:0] mx[10] = '{8'h64, 8'h64, 8'h7f, 8'h7f, 8'h07, 8'h04, 8'h01, 8'h09, 8'h02, 8'h01};
   logic [7:0] st[10] = '{8'h14, 8'h14, 8'h07, 8'h07, 8'h03, 8'h00, 8'h01, 8'h05, 8'h00, 8'h00};
   // Design, host model
   ddc_regs #(.STEP_CYCLES(STEP)) DUT (.mclk_in(mclk_in), .resetn_in(resetn_in), .cmd_in(cmd),
      .rsp_out(rsp), .analog_sens_en_in(an_en), .analog_sens_in(an_val), .auto_rate_en_in(au_en),
      .auto_rate_in(au_val), .random_chan_en_in(rc_en), .random_chan_in(rc_val),
      .pin_mode_in(pin), .approach_sense_in(ap_s), .leave_sense_in(lv_s),
      .approach_sens_out(ap_sens), .leave_sens_out(lv_sens), .target_velocity_out(vel),
      .sampling_rate_out(rate), .noise_filter_en_out(nf), .tx_channel_out(ch),
      .approach_detect_out(ap_d), .leave_detect_out(lv_d), .multi_mode_output_pin_out(multi_mode_output_pin));
   ddc_host host (.mclk_in(mclk_in), .rsp_in(rsp), .cmd_out(cmd));
   // Clock, 5 ns period
   initial forever #2.5 mclk_in = ~mclk_in;
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (error_cnt == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Velocity needs a least rate code of velocity minus three
   function automatic logic pair_bad(input logic [7:0] v, input logic [7:0] s);
      return (v > 8'h03) && (s < v - 8'h03);
   endfunction
   // One command with its expected answer worked out from the shadow copy
   task automatic cmd_io(input int i, input logic wr, input logic [7:0] dat);
      logic [7:0] old;
      logic bad;
      old = st[i];
      bad = wr && (dat > mx[i] || (!au_en && ((i == 4 && pair_bad(dat, st[5]))
            || (i == 5 && pair_bad(st[4], dat)))));
      host.send(wr, ad[i], dat, r);
      chk("rsp_valid", r.valid, 1'b1);
      chk("rsp_error", r.error, bad);
      chk("rsp_data", r.data, old);
      if (wr && !bad) st[i] = dat;
   endtask
   task automatic chk_out();
      @(posedge mclk_in);
      #1 chk("approach_sens", ap_sens, an_en ? an_val : st[0]);
      chk("leave_sens", lv_sens, an_en ? an_val : st[1]);
      chk("velocity", vel, st[4]);
      chk("rate", rate, au_en ? au_val : st[5]);
      chk("noise", nf, st[6][0]);
      chk("channel", ch, rc_en ? rc_val : st[7]);
   endtask
   task automatic set_auto(input logic v);
      @(posedge mclk_in);
      au_en <= v;
      #1;
   endtask
   // Short run must not declare; a full run declares within its window
   task automatic measure(input logic lv, input int code);
      int t;
      t = 0;
      cmd_io(lv ? 3 : 2, 1'b1, 8'(code));
      @(posedge mclk_in);
      if (lv) lv_s <= 1'b1; else ap_s <= 1'b1;
      repeat ((code + 1) * STEP - 1) @(posedge mclk_in);
      if (lv) lv_s <= 1'b0; else ap_s <= 1'b0;
      repeat (3) @(posedge mclk_in);
      #1 chk("early", lv ? lv_d : ap_d, 1'b0);
      @(posedge mclk_in);
      if (lv) lv_s <= 1'b1; else ap_s <= 1'b1;
      while ((lv ? lv_d : ap_d) !== 1'b1 && t < 1000) begin
         @(posedge mclk_in);
         #1 t++;
      end
      chk("delay", t > (code + 1) * STEP && t <= (code + 1) * STEP + 3, 1'b1);
      if (t >= 1000) give_verdict();
   endtask
   // Every condition, inversion and pin mode against the present sense levels
   task automatic pin_sweep();
      logic e;
      for (int c = 0; c < 3; c++) begin
         for (int v = 0; v < 8; v++) begin
            @(posedge mclk_in);
            pin <= 2'(v % 4);
            cmd_io(8, 1'b1, 8'(c));
            cmd_io(9, 1'b1, 8'(v / 4));
            e = ((c == 0) ? (ap_s | lv_s) : (c == 1) ? ap_s : lv_s) ^ (v > 3);
            @(posedge mclk_in);
            #1 chk("pin", multi_mode_output_pin, (v % 4 >= 2) ? 1'b0 : e);
         end
      end
   endtask
   // Main sequence
   initial begin
      void'($urandom(51));
      repeat (12) @(posedge mclk_in);
      resetn_in <= 1'b1;
      for (int i = 0; i < 10; i++) cmd_io(i, 1'b0, 8'h00);
      host.send(1'b0, 8'h80, 8'h00, r);
      chk("unmapped_error", r.error, 1'b1);
      chk("unmapped_data", r.data, 8'h00);
      set_auto(1'b0);
      cmd_io(4, 1'b1, 8'h07);
      set_auto(1'b1);
      cmd_io(4, 1'b1, 8'h07);
      cmd_io(5, 1'b1, 8'h00);
      set_auto(1'b0);
      cmd_io(5, 1'b1, 8'h03);
      cmd_io(5, 1'b1, 8'h04);
      chk_out();
      for (int n = 0; n < 60; n++) begin
         @(posedge mclk_in);
         {an_en, au_en, rc_en} <= 3'($urandom);
         an_val <= 7'($urandom_range(100));
         au_val <= 3'($urandom_range(4));
         rc_val <= 4'($urandom_range(9));
         #1 k = $urandom_range(9);
         d = (n % 3 == 0) ? mx[k] + 8'h01 : 8'($urandom_range(mx[k]));
         cmd_io(k, 1'b1, d);
         chk_out();
      end
      measure(1'b0, 0);
      pin_sweep();
      measure(1'b1, 1);
      pin_sweep();
      @(posedge mclk_in);
      ap_s <= 1'b0;
      repeat (3) @(posedge mclk_in);
      #1 chk("approach_drop", ap_d, 1'b0);
      pin_sweep();
      give_verdict();
   end
endmodule
bind ddc_regs ddc_regs_sva #(.STEP_CYCLES(STEP_CYCLES)) u_sva (.mclk_in(mclk_in),
   .resetn_in(resetn_in), .cmd_in(cmd_in), .rsp_out(rsp_out), .analog_sens_in(analog_sens_in),
   .analog_sens_en_in(analog_sens_en_in), .auto_rate_en_in(auto_rate_en_in),
   .auto_rate_in(auto_rate_in), .random_chan_en_in(random_chan_en_in),
   .random_chan_in(random_chan_in), .pin_mode_in(pin_mode_in), .leave_sense_in(leave_sense_in),
   .approach_sense_in(approach_sense_in), .approach_sens_out(approach_sens_out),
   .leave_sens_out(leave_sens_out), .target_velocity_out(target_velocity_out),
   .sampling_rate_out(sampling_rate_out), .noise_filter_en_out(noise_filter_en_out),
   .tx_channel_out(tx_channel_out), .approach_detect_out(approach_detect_out),
   .leave_detect_out(leave_detect_out), .multi_mode_output_pin_out(multi_mode_output_pin_out));
